// [verilog/phs_pkg.sv]
// constants, codes and types for the peak hold and settings block
`default_nettype none
package phs_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CORE_CLK_HZ = 25_000_000;
    localparam int unsigned MS_CYC      = CORE_CLK_HZ / 1000;
    // clear intervals in ms, index 1..6 of the clear code
    localparam int unsigned CLR_MS_1 = 100;
    localparam int unsigned CLR_MS_2 = 250;
    localparam int unsigned CLR_MS_3 = 500;
    localparam int unsigned CLR_MS_4 = 1000;
    localparam int unsigned CLR_MS_5 = 5000;
    localparam int unsigned CLR_MS_6 = 25000;

    // ****************************************
    // setting limits and defaults
    // ****************************************
    localparam logic [15:0] EMIS_MIN      = 16'h0064; // 10.0 %
    localparam logic [15:0] EMIS_MAX      = 16'h04E2; // 125.0 %
    localparam logic [15:0] EMIS_RST      = 16'h03E8; // 100.0 %
    localparam logic [15:0] SUB_SPAN_MIN  = 16'h01FE; // 51.0 degC
    localparam logic [15:0] AUTO_STEP_MIN = 16'h0014; // 2.0 degC
    localparam logic [15:0] AUTO_PCT_DIV  = 16'h0064; // 1 % of limit
    localparam logic [16:0] BAUD_MIN      = 17'h004B0; // 1200
    localparam logic [16:0] BAUD_MAX      = 17'h1C138; // 115000
    localparam logic [16:0] BAUD_RST      = 17'h04B00; // 19200
    localparam logic [6:0]  ADDR_RST      = 7'h00;
    localparam logic [6:0]  ADDR_OWN_MAX  = 7'h61;    // 97
    localparam logic [6:0]  ADDR_ALL_SET  = 7'h62;    // 98
    localparam logic [6:0]  ADDR_ANY      = 7'h63;    // 99
    localparam logic [1:0]  AOUT_RST      = 2'h1;     // 4..20 mA, no low flag
    localparam logic [3:0]  CLR_CODE_RST  = 4'h0;     // off
    localparam logic [3:0]  CLR_CODE_EXT  = 4'h7;
    localparam logic [3:0]  CLR_CODE_AUTO = 4'h8;
    localparam logic        USE_MIN_RST   = 1'b0;     // maximum storage

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0] {
        PHS_OFF   = 2'b00,
        PHS_TIMED = 2'b01,
        PHS_EXT   = 2'b10,
        PHS_AUTO  = 2'b11
    } phs_mode_t;

    typedef enum logic [2:0] {
        PHS_SEL_EMIS = 3'b000,
        PHS_SEL_AOUT = 3'b001,
        PHS_SEL_CLRT = 3'b010,
        PHS_SEL_MINM = 3'b011,
        PHS_SEL_SUBR = 3'b100,
        PHS_SEL_BAUD = 3'b101,
        PHS_SEL_ADDR = 3'b110,
        PHS_SEL_FACT = 3'b111
    } phs_sel_t;

    // clear interval in ms for a timed clear code, zero otherwise
    function automatic logic [31:0] phs_clr_ms(input logic [3:0] code);
        logic [31:0] ms;
        ms = 32'h0000_0000;
        case (code)
            4'h1:    ms = 32'(CLR_MS_1);
            4'h2:    ms = 32'(CLR_MS_2);
            4'h3:    ms = 32'(CLR_MS_3);
            4'h4:    ms = 32'(CLR_MS_4);
            4'h5:    ms = 32'(CLR_MS_5);
            4'h6:    ms = 32'(CLR_MS_6);
            default: ms = 32'h0000_0000;
        endcase
        return ms;
    endfunction
endpackage
`default_nettype wire

// [verilog/phs_peak_cell.sv]
// one peak register: tracks highest or lowest sample since its last clear
`timescale 1ns/100ps
`default_nettype none
module phs_peak_cell #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         flush,
    input  wire logic         clr,
    input  wire logic         smp_vld,
    input  wire logic [W-1:0] smp_val,
    input  wire logic         use_min,
    output logic      [W-1:0] val_q,
    output logic              full_q
);
    typedef struct packed {
        logic [W-1:0] val;
        logic         full;
    } phs_cell_t;

    phs_cell_t st_q;
    phs_cell_t st_d;
    logic      better;

    // a sample beats the held value in the selected direction
    always_comb
    begin
        better = use_min ? (smp_val < st_q.val) : (smp_val > st_q.val);
        st_d = st_q;
        if (flush)
        begin
            st_d.full = 1'b0;
        end
        else if (clr)
        begin
            // a clear starts a fresh peak, seeded by a coincident sample
            st_d.full = smp_vld;
            st_d.val  = smp_vld ? smp_val : st_q.val;
        end
        else if (smp_vld && (!st_q.full || better))
        begin
            st_d.full = 1'b1;
            st_d.val  = smp_val;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign val_q  = st_q.val;
    assign full_q = st_q.full;
endmodule
`default_nettype wire

// [verilog/phs_peak_hold.sv]
// settings store, peak hold and bus address match of the instrument
// What this block does
// - factory defaults: 19200 baud, address 00
// - default: maximum storage, timed clearing off
// - emissivity accepted only 10 to 125 percent
// - analog range select, low variant forces 21mA
// - storage off passes momentary values only
// - six clear times select double storage
// - two registers cleared alternately, older one shown
// - external mode: single register, host clear
// - auto: clear on rise above low limit plus larger of 1 % and 2 degC
// - auto without limit: uses range bottom
// - minimum storage tracks lowest, same clearing
// - storage sees only smoothed samples
// - sub-range accepted only with 51 degC span
// - respond only to own unique address
// - address 98 applies settings on all units
// - address 99 always answered, single unit
// - characters: eight bits, even parity, stop
// - command: two-digit address, letters, CR
// - query answers value, setting answers ok
// - baud configurable from 1200 to 115000
`timescale 1ns/100ps
`default_nettype none
module phs_peak_hold #(
    parameter int          TW         = 16,
    parameter int unsigned CYC_PER_MS = phs_pkg::MS_CYC,
    parameter logic [15:0] RANGE_LO   = 16'h0FA0,
    parameter logic [15:0] RANGE_HI   = 16'h2AF8
) (
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          cfg_wr,
    input  wire logic [2:0]    cfg_sel,
    input  wire logic [16:0]   cfg_val,
    input  wire logic [15:0]   cfg_val2,
    input  wire logic          filt_vld,
    input  wire logic [TW-1:0] filt_temp,
    input  wire logic          sig_low,
    input  wire logic          external_hold_clear_cmd,
    input  wire logic          cmd_vld,
    input  wire logic [6:0]    cmd_addr,
    input  wire logic          cmd_is_set,
    input  wire logic [7:0]    tx_char,
    output logic [15:0]        emis_q,
    output logic [1:0]         aout_mode_q,
    output logic               aout_21ma_q,
    output logic               sub_en_q,
    output logic [15:0]        sub_lo_q,
    output logic [15:0]        sub_hi_q,
    output logic [16:0]        baud_q,
    output logic [6:0]         device_bus_address_q,
    output logic [3:0]         hold_clear_time_q,
    output logic               use_min_q,
    output logic [TW-1:0]      hold_out_q,
    output logic               cfg_ok_q,
    output logic               cfg_err_q,
    output logic               cmd_take_q,
    output logic               cmd_reply_q,
    output logic               cmd_ok_q,
    output logic               tx_par_q
);
    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // assert at once, release after two edges so all flops leave reset together
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [15:0]   emis;
        logic [1:0]    aout;
        logic          a21;
        logic          sub_en;
        logic [15:0]   sub_lo;
        logic [15:0]   sub_hi;
        logic [16:0]   baud;
        logic [6:0]    addr;
        logic [3:0]    clr_code;
        logic          use_min;
        logic [31:0]   tmr;
        logic          phase;
        logic          above;
        logic          flush;
        logic [TW-1:0] out;
        logic          cfg_ok;
        logic          cfg_err;
        logic          take;
        logic          reply;
        logic          ok;
        logic          par;
    } phs_state_t;

    phs_state_t          st_q;
    phs_state_t          st_d;
    phs_pkg::phs_mode_t  mode;
    logic [31:0]         ivl_cyc;
    logic                bnd;
    logic [15:0]         thr;
    logic [15:0]         pct;
    logic                rise;
    logic                clr_a;
    logic                clr_b;
    logic [TW-1:0]       val_a;
    logic [TW-1:0]       val_b;
    logic                full_a;
    logic                full_b;
    logic                own_hit;

    // ****************************************
    // clear timing and object detection
    // ****************************************
    // clear code to mode
    always_comb
    begin
        if (st_q.clr_code == phs_pkg::CLR_CODE_RST)
            mode = phs_pkg::PHS_OFF;
        else if (st_q.clr_code == phs_pkg::CLR_CODE_EXT)
            mode = phs_pkg::PHS_EXT;
        else if (st_q.clr_code == phs_pkg::CLR_CODE_AUTO)
            mode = phs_pkg::PHS_AUTO;
        else
            mode = phs_pkg::PHS_TIMED;
    end

    assign ivl_cyc = phs_pkg::phs_clr_ms(st_q.clr_code) * 32'(CYC_PER_MS);
    assign bnd     = (mode == phs_pkg::PHS_TIMED) && (st_q.tmr >= ivl_cyc - 32'h0000_0001);

    // threshold is low limit plus larger of 1 % and 2 degC
    assign pct = st_q.sub_lo / phs_pkg::AUTO_PCT_DIV;
    // without a sub-range the range bottom is the threshold
    assign thr = st_q.sub_en ? st_q.sub_lo + ((pct > phs_pkg::AUTO_STEP_MIN) ? pct : phs_pkg::AUTO_STEP_MIN)
                             : RANGE_LO;
    // a new object is the first smoothed sample above the threshold
    assign rise = filt_vld && (16'(filt_temp) > thr) && !st_q.above;

    // alternate clears in timed mode, register a in external and auto modes
    assign clr_a = (mode == phs_pkg::PHS_TIMED) ? (bnd && !st_q.phase) :
                   (mode == phs_pkg::PHS_EXT) ? external_hold_clear_cmd :
                   (mode == phs_pkg::PHS_AUTO) && rise;
    assign clr_b = bnd && st_q.phase;

    // cells only ever see the filtered sample stream
    phs_peak_cell #(
        .W (TW)
    ) u_cell_a (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .flush    (st_q.flush),
        .clr      (clr_a),
        .smp_vld  (filt_vld),
        .smp_val  (filt_temp),
        .use_min  (st_q.use_min),
        .val_q    (val_a),
        .full_q   (full_a)
    );

    phs_peak_cell #(
        .W (TW)
    ) u_cell_b (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .flush    (st_q.flush),
        .clr      (clr_b),
        .smp_vld  (filt_vld),
        .smp_val  (filt_temp),
        .use_min  (st_q.use_min),
        .val_q    (val_b),
        .full_q   (full_b)
    );

    // own address only valid in the individual range
    assign own_hit = (cmd_addr == st_q.addr) && (cmd_addr <= phs_pkg::ADDR_OWN_MAX);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_d         = st_q;
        st_d.flush   = 1'b0;
        st_d.cfg_ok  = 1'b0;
        st_d.cfg_err = 1'b0;
        st_d.take    = 1'b0;
        st_d.reply   = 1'b0;
        st_d.ok      = 1'b0;
        // even parity over the outgoing character
        st_d.par     = ^tx_char;
        // 21 mA forced while the low variant sees a weak signal
        st_d.a21     = st_q.aout[1] && sig_low;
        if (filt_vld)
            st_d.above = 16'(filt_temp) > thr;

        if (mode != phs_pkg::PHS_TIMED || bnd)
            st_d.tmr = 32'h0000_0000;
        else
            st_d.tmr = st_q.tmr + 32'h0000_0001;
        if (bnd)
            st_d.phase = !st_q.phase;

        // off passes momentary values; else show the held register
        if (mode == phs_pkg::PHS_OFF)
            st_d.out = filt_vld ? filt_temp : st_q.out;
        // the register not cleared last holds the older peak
        else if (mode == phs_pkg::PHS_TIMED && st_q.phase)
            st_d.out = full_b ? val_b : filt_temp;
        else
            st_d.out = full_a ? val_a : filt_temp;

        // address 98 applies settings, answers nothing
        // address 99 always taken and answered
        if (cmd_vld && (own_hit || cmd_addr == phs_pkg::ADDR_ANY ||
                        (cmd_addr == phs_pkg::ADDR_ALL_SET && cmd_is_set)))
        begin
            st_d.take  = 1'b1;
            st_d.reply = cmd_addr != phs_pkg::ADDR_ALL_SET;
            // a setting answers ok, a query answers a value
            st_d.ok    = cmd_is_set;
        end

        if (cfg_wr)
        begin
            st_d.cfg_ok = 1'b1;
            case (phs_pkg::phs_sel_t'(cfg_sel))
                phs_pkg::PHS_SEL_EMIS:
                begin
                    if (cfg_val[15:0] >= phs_pkg::EMIS_MIN && cfg_val[15:0] <= phs_pkg::EMIS_MAX && !cfg_val[16])
                        st_d.emis = cfg_val[15:0];
                    else
                        st_d.cfg_ok = 1'b0;
                end
                phs_pkg::PHS_SEL_AOUT:
                    // bit0 selects 4..20 mA, bit1 the 21 mA variant
                    st_d.aout = cfg_val[1:0];
                phs_pkg::PHS_SEL_CLRT:
                begin
                    // a new clear setting empties both registers
                    if (cfg_val <= 17'(phs_pkg::CLR_CODE_AUTO))
                    begin
                        st_d.clr_code = cfg_val[3:0];
                        st_d.flush    = 1'b1;
                        st_d.tmr      = 32'h0000_0000;
                        st_d.phase    = 1'b0;
                    end
                    else
                        st_d.cfg_ok = 1'b0;
                end
                phs_pkg::PHS_SEL_MINM:
                begin
                    // minimum storage, same clearing, fresh start
                    st_d.use_min = cfg_val[0];
                    st_d.flush   = 1'b1;
                    st_d.tmr     = 32'h0000_0000;
                    st_d.phase   = 1'b0;
                end
                phs_pkg::PHS_SEL_SUBR:
                begin
                    // zero span disables, otherwise need 51 degC inside range
                    if (cfg_val[15:0] == cfg_val2)
                        st_d.sub_en = 1'b0;
                    else if (cfg_val2 > cfg_val[15:0] && cfg_val2 - cfg_val[15:0] >= phs_pkg::SUB_SPAN_MIN &&
                             cfg_val[15:0] >= RANGE_LO && cfg_val2 <= RANGE_HI)
                    begin
                        st_d.sub_en = 1'b1;
                        st_d.sub_lo = cfg_val[15:0];
                        st_d.sub_hi = cfg_val2;
                    end
                    else
                        st_d.cfg_ok = 1'b0;
                end
                phs_pkg::PHS_SEL_BAUD:
                begin
                    // baud limited to the documented span
                    if (cfg_val >= phs_pkg::BAUD_MIN && cfg_val <= phs_pkg::BAUD_MAX)
                        st_d.baud = cfg_val;
                    else
                        st_d.cfg_ok = 1'b0;
                end
                phs_pkg::PHS_SEL_ADDR:
                begin
                    // 98 and 99 are shared and cannot be owned
                    if (cfg_val <= 17'(phs_pkg::ADDR_OWN_MAX))
                        st_d.addr = cfg_val[6:0];
                    else
                        st_d.cfg_ok = 1'b0;
                end
                default:
                begin
                    // factory load restores serial rate and address
                    st_d.baud     = phs_pkg::BAUD_RST;
                    st_d.addr     = phs_pkg::ADDR_RST;
                    st_d.emis     = phs_pkg::EMIS_RST;
                    st_d.aout     = phs_pkg::AOUT_RST;
                    // maximum storage with timed clearing off
                    st_d.clr_code = phs_pkg::CLR_CODE_RST;
                    st_d.use_min  = phs_pkg::USE_MIN_RST;
                    st_d.sub_en   = 1'b0;
                    st_d.flush    = 1'b1;
                    st_d.tmr      = 32'h0000_0000;
                    st_d.phase    = 1'b0;
                end
            endcase
            st_d.cfg_err = !st_d.cfg_ok;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q          <= '0;
            st_q.emis     <= phs_pkg::EMIS_RST;
            st_q.aout     <= phs_pkg::AOUT_RST;
            st_q.baud     <= phs_pkg::BAUD_RST;
            st_q.addr     <= phs_pkg::ADDR_RST;
            st_q.clr_code <= phs_pkg::CLR_CODE_RST;
            st_q.use_min  <= phs_pkg::USE_MIN_RST;
        end
        else
            st_q <= st_d;
    end

    assign emis_q               = st_q.emis;
    assign aout_mode_q          = st_q.aout;
    assign aout_21ma_q          = st_q.a21;
    assign sub_en_q             = st_q.sub_en;
    assign sub_lo_q             = st_q.sub_lo;
    assign sub_hi_q             = st_q.sub_hi;
    assign baud_q               = st_q.baud;
    assign device_bus_address_q = st_q.addr;
    assign hold_clear_time_q    = st_q.clr_code;
    assign use_min_q            = st_q.use_min;
    assign hold_out_q           = st_q.out;
    assign cfg_ok_q             = st_q.cfg_ok;
    assign cfg_err_q            = st_q.cfg_err;
    assign cmd_take_q           = st_q.take;
    assign cmd_reply_q          = st_q.reply;
    assign cmd_ok_q             = st_q.ok;
    assign tx_par_q             = st_q.par;

    // ****************************************
    // checks
    // ****************************************
    emis_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        emis_q >= phs_pkg::EMIS_MIN && emis_q <= phs_pkg::EMIS_MAX)
        else $error("emissivity outside accepted span");
    emis_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg_wr && cfg_sel == 3'h0 && cfg_val < 17'(phs_pkg::EMIS_MIN) |=> cfg_err_q && $stable(emis_q))
        else $error("low emissivity was applied");
    addr_any_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmd_vld && cmd_addr == phs_pkg::ADDR_ANY |=> cmd_take_q && cmd_reply_q)
        else $error("address 99 not answered");
    addr_all_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmd_vld && cmd_addr == phs_pkg::ADDR_ALL_SET && cmd_is_set |=> cmd_take_q && !cmd_reply_q && cmd_ok_q)
        else $error("address 98 setting mishandled");
    addr_foreign_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmd_vld && cmd_addr != device_bus_address_q && cmd_addr < phs_pkg::ADDR_ALL_SET |=> !cmd_take_q)
        else $error("foreign address taken");
    off_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        hold_clear_time_q == 4'h0 && filt_vld |=> hold_out_q == $past(filt_temp))
        else $error("off mode did not pass sample");
    sub_span_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sub_en_q |-> sub_hi_q > sub_lo_q && sub_hi_q - sub_lo_q >= phs_pkg::SUB_SPAN_MIN)
        else $error("sub-range span too small");
    alt_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bnd && !cfg_wr |-> clr_a != clr_b ##1 st_q.phase != $past(st_q.phase))
        else $error("double storage did not alternate");
    low_21ma_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 aout_21ma_q == $past(aout_mode_q[1] && sig_low))
        else $error("21 mA flag wrong");
    baud_span_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        baud_q >= phs_pkg::BAUD_MIN && baud_q <= phs_pkg::BAUD_MAX)
        else $error("baud outside span");
endmodule
`default_nettype wire

// [tb/phs_host_model.sv]
// host side model: parsed commands and external clear pulses
`timescale 1ns/100ps
`default_nettype none
module phs_host_model (
    input  wire logic       core_clk,
    output logic            cmd_vld,
    output logic [6:0]      cmd_addr,
    output logic            cmd_is_set,
    output logic            clr_cmd
);
    initial
    begin
        cmd_vld = 1'b0;
        cmd_addr = 7'h7F;
        cmd_is_set = 1'b0;
        clr_cmd = 1'b0;
    end
    // two-digit address, 99 with one unit
    task automatic send(input logic [6:0] a, input logic s);
        cmd_vld = 1'b1;
        cmd_addr = a;
        cmd_is_set = s;
        @(posedge core_clk);
        #1 cmd_vld = 1'b0;
        cmd_addr = ~a; // idle field no longer shows the old address
    endtask
    task automatic clear();
        clr_cmd = 1'b1;
        @(posedge core_clk);
        #1 clr_cmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/phs_peak_hold_tb_top.sv]
// self-checking bench for the peak hold and settings block
`timescale 1ns/100ps
`default_nettype none
module phs_peak_hold_tb_top;
    logic        clk, rst_b, cfg_wr, fv, sig_low, clr, cv, cs, a21, sen, umin, cok, cerr, tk, rp, ok, par;
    logic [2:0]  sel;
    logic [16:0] val, baud;
    logic [15:0] val2, temp, emis, slo, shi, hold;
    logic [7:0]  txc;
    logic [6:0]  ca, adr;
    logic [3:0]  clt;
    logic [1:0]  am;
    int          bad_count = 0;
    int          checks_done = 0;
    // short millisecond keeps timed intervals at 4 cycles per ms
    phs_peak_hold #(.CYC_PER_MS(4)) dut (.core_clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_sel(sel),
        .cfg_val(val), .cfg_val2(val2), .filt_vld(fv), .filt_temp(temp), .sig_low(sig_low),
        .external_hold_clear_cmd(clr), .cmd_vld(cv), .cmd_addr(ca), .cmd_is_set(cs), .tx_char(txc),
        .emis_q(emis), .aout_mode_q(am), .aout_21ma_q(a21), .sub_en_q(sen), .sub_lo_q(slo), .sub_hi_q(shi),
        .baud_q(baud), .device_bus_address_q(adr), .hold_clear_time_q(clt), .use_min_q(umin),
        .hold_out_q(hold), .cfg_ok_q(cok), .cfg_err_q(cerr), .cmd_take_q(tk), .cmd_reply_q(rp),
        .cmd_ok_q(ok), .tx_par_q(par));
    phs_host_model host (.core_clk(clk), .cmd_vld(cv), .cmd_addr(ca), .cmd_is_set(cs), .clr_cmd(clr));
    task automatic chk(input string n, input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // one setting write, answer looked at in its single cycle
    task automatic cfg(input logic [2:0] s, input logic [16:0] v, input logic [15:0] v2, input logic good);
        cfg_wr = 1'b1;
        sel = s;
        val = v;
        val2 = v2;
        @(posedge clk);
        #1 cfg_wr = 1'b0;
        chk("cfg_ok", 17'(cok), 17'(good));
        chk("cfg_err", 17'(cerr), 17'(!good));
        // idle edge: strobe is never re-raised in the step it falls, and a flush lands before the next sample
        cyc(1);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one sample, then the cycle in which the output follows
    task automatic smp(input logic [15:0] t);
        fv = 1'b1;
        temp = t;
        cyc(1);
        fv = 1'b0;
        cyc(1);
    endtask
    task automatic cmd(input logic [6:0] a, input logic s, input logic [2:0] e);
        host.send(a, s);
        chk("cmd", 17'({tk, rp, ok}), 17'(e));
        // idle edge so back-to-back commands never retoggle the valid in one step
        cyc(1);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {rst_b, cfg_wr, sel, val, val2, fv, temp, sig_low, txc} = '0;
        cyc(16);
        rst_b = 1'b1;
        cyc(3);
        chk("baud", baud, 17'h04B00);
        chk("addr", 17'(adr), 17'h0);
        chk("clr", 17'(clt), 17'h0);
        chk("min", 17'(umin), 17'h0);
        cfg(3'h0, 17'h63, 16'h0, 1'b0);
        cfg(3'h0, 17'h4E3, 16'h0, 1'b0);
        cfg(3'h0, 17'h64, 16'h0, 1'b1);
        chk("emis", 17'(emis), 17'h64);
        sig_low = 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            cfg(3'h1, 17'(m), 16'h0, 1'b1);
            cyc(1);
            chk("a21", 17'(a21), 17'(m[1]));
        end
        chk("aout", 17'(am), 17'h3);
        // off mode: momentary values, unflagged temps ignored
        smp(16'h01F4);
        smp(16'h012C);
        temp = 16'h03E7;
        cyc(2);
        chk("off", 17'(hold), 17'h12C);
        cfg(3'h2, 17'h7, 16'h0, 1'b1);
        smp(16'h0258);
        smp(16'h0190);
        chk("ext", 17'(hold), 17'h258);
        host.clear();
        smp(16'h01C2);
        chk("extclr", 17'(hold), 17'h1C2);
        cfg(3'h3, 17'h1, 16'h0, 1'b1);
        smp(16'h0258);
        smp(16'h0190);
        smp(16'h01F4);
        chk("min", 17'(hold), 17'h190);
        cfg(3'h3, 17'h0, 16'h0, 1'b1);
        // auto without sub-range: range bottom is the trigger
        cfg(3'h2, 17'h8, 16'h0, 1'b1);
        smp(16'h0BB8);
        smp(16'h1388);
        smp(16'h0BB8);
        smp(16'h1194);
        chk("auto", 17'(hold), 17'h1194);
        cfg(3'h4, 17'h1388, 16'h1585, 1'b0);
        cfg(3'h4, 17'h1388, 16'h1770, 1'b1);
        chk("sub_lo", {sen, slo}, 17'h11388);
        chk("sub_hi", 17'(shi), 17'h1770);
        smp(16'h0FA0);
        smp(16'h1770);
        smp(16'h0FA0);
        smp(16'h13BA);
        chk("auto_at", 17'(hold), 17'h1770);
        smp(16'h13BB);
        chk("auto_up", 17'(hold), 17'h13BB);
        for (int c = 1; c < 7; c++)
            cfg(3'h2, 17'(c), 16'h0, 1'b1);
        cfg(3'h2, 17'h9, 16'h0, 1'b0);
        // 0.1 s is 400 cycles here, far above three response times
        cfg(3'h2, 17'h1, 16'h0, 1'b1);
        fv = 1'b1;
        temp = 16'h02BC;
        cyc(1);
        temp = 16'h01F4;
        cyc(450);
        chk("dbl1", 17'(hold), 17'h2BC);
        cyc(400);
        chk("dbl2", 17'(hold), 17'h1F4);
        fv = 1'b0;
        cfg(3'h6, 17'h5, 16'h0, 1'b1);
        cfg(3'h6, 17'h62, 16'h0, 1'b0);
        cmd(7'h05, 1'b0, 3'b110);
        cmd(7'h05, 1'b1, 3'b111);
        cmd(7'h06, 1'b1, 3'b000);
        cmd(7'h62, 1'b1, 3'b101);
        cmd(7'h62, 1'b0, 3'b000);
        cmd(7'h63, 1'b0, 3'b110);
        cfg(3'h5, 17'h004AF, 16'h0, 1'b0);
        cfg(3'h5, 17'h1C138, 16'h0, 1'b1);
        cfg(3'h7, 17'h0, 16'h0, 1'b1);
        chk("fbaud", baud, 17'h04B00);
        chk("faddr", 17'(adr), 17'h0);
        chk("fclr", 17'(clt), 17'h0);
        txc = 8'h07;
        cyc(1);
        chk("par", 17'(par), 17'h1);
        txc = 8'h03;
        cyc(1);
        chk("par0", 17'(par), 17'h0);
        complete_run();
    end
endmodule
`default_nettype wire
